// ===== src/pld_pkg.sv
// Shared constants and field layouts of the lock detector and bias register bank.
// Assumes a single core clock and a plain word-wide register port.
package pld_pkg;

	// ---------------------------------------------------------------
	// Register indices (printed offsets) and own additions
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_LOCK_DETECT  = 8'h07;
	localparam logic [7:0] ADDR_ANALOG_EN    = 8'h08;
	localparam logic [7:0] ADDR_CHARGE_PUMP  = 8'h09;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h11;
	localparam logic [7:0] ADDR_IRQ_CLEAR    = 8'h12;
	localparam logic [7:0] ADDR_DETECT_STATE = 8'h13;

	// ---------------------------------------------------------------
	// Field layouts, most significant field first
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       auto_relock;    // [13]
		logic       timer_test;     // [12]
		logic [1:0] timer_rate;     // [11:10]
		logic [2:0] win_len;        // [9:7]
		logic       win_digital;    // [6]
		logic [1:0] rsvd_5_4;       // [5:4]
		logic       ld_enable;      // [3]
		logic [2:0] win_count;      // [2:0]
	} pld_lock_cfg_t;

	typedef struct packed {
		logic       rsvd_23;
		logic       rsvd_22;
		logic       hi_freq_ref;    // [21]
		logic       rsvd_20;
		logic       div2_enable;    // [19]
		logic       rsvd_18;
		logic [2:0] resync_bias;    // [17:15]
		logic [2:0] rf_buf_bias;    // [14:12]
		logic       opamp_enable;   // [11]
		logic       vco_bias_enable;
		logic       prescaler_clock_enable;
		logic       rsvd_8;
		logic       divider_clock_to_logic_enable;
		logic       spare_6;
		logic       shared_output_pad_enable;
		logic       vco_buf_enable;
		logic       ref_buf_enable;
		logic       phase_compare_enable;
		logic       pump_enable;
		logic       bias_enable;    // [0]
	} pld_analog_cfg_t;

	typedef struct packed {
		logic       high_gain_pump_mode; // [23]
		logic       offset_down;    // [22]
		logic       offset_up;      // [21]
		logic [6:0] offset_code;    // [20:14]
		logic [6:0] up_gain;        // [13:7]
		logic [6:0] down_gain;      // [6:0]
	} pld_pump_cfg_t;

	// ---------------------------------------------------------------
	// Reset values and widths
	// ---------------------------------------------------------------
	localparam int          LOCK_CFG_W      = 14;
	localparam int          WIDE_CFG_W      = 24;
	localparam logic [13:0] LOCK_CFG_RESET  = 14'h000d;
	localparam logic [23:0] ANALOG_RESET    = 24'hc1beff;
	localparam logic [23:0] PUMP_RESET      = 24'h40050a;
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_LOCKED      = 0;
	localparam int          IRQ_LOST        = 1;
	localparam int          IRQ_RELOCK      = 2;

	// Consecutive in-window comparisons needed per count code
	function automatic logic [15:0] lock_target(input logic [2:0] code);
		case (code)
			3'h0:    lock_target = 16'h0005;
			3'h1:    lock_target = 16'h0020;
			3'h2:    lock_target = 16'h0060;
			3'h3:    lock_target = 16'h0100;
			3'h4:    lock_target = 16'h0200;
			3'h5:    lock_target = 16'h0800;
			3'h6:    lock_target = 16'h2000;
			default: lock_target = 16'hffff;
		endcase
	endfunction

endpackage

// ===== src/pld_regs.sv
// Register bank and digital lock detector of a fractional-N synthesizer core.
// Assumes ref_edge and vco_edge are one-cycle pulses synchronous to core_clk,
// and that register strobes follow the plain single-cycle port protocol.
`timescale 1ns/100ps

module pld_regs (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	// Comparison events and analog window result
	input  wire logic                      ref_edge,
	input  wire logic                      vco_edge,
	input  wire logic                      analog_in_window,
	// Configuration to the analog sections
	output pld_pkg::pld_lock_cfg_t         lock_cfg,
	output pld_pkg::pld_analog_cfg_t       analog_cfg,
	output pld_pkg::pld_pump_cfg_t         pump_cfg,
	output logic                           high_gain_pump_mode,
	// Lock status, relock request and interrupt
	output logic                           lock_detected,
	output logic                           relock_request,
	output logic                           irq,
	// Shared lock output pin
	output logic                           lock_serial_out_pin_o,
	output logic                           lock_serial_out_pin_oe
);

	// ---------------------------------------------------------------
	// Register port decode
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {LD_OFF, LD_HUNT, LD_LOCKED} pld_state_t;

	pld_pkg::pld_lock_cfg_t   lock_r;
	pld_pkg::pld_analog_cfg_t analog_r;
	pld_pkg::pld_pump_cfg_t   pump_r;
	logic [pld_pkg::IRQ_W-1:0] status_r;
	logic [pld_pkg::IRQ_W-1:0] status_nxt;
	logic [pld_pkg::IRQ_W-1:0] irq_en_r;
	logic [pld_pkg::IRQ_W-1:0] irq_set;
	logic [31:0]               rdata_nxt;
	pld_state_t                state_r;
	pld_state_t                state_nxt;
	logic [15:0]               good_cnt_r;
	logic [15:0]               good_cnt_nxt;
	logic [2:0]                rate_cnt_r;
	logic [7:0]                win_cnt_r;
	logic                      win_open_r;
	logic                      relock_used_r;
	logic                      relock_nxt;

	wire wr_lock   = reg_wr && (reg_addr == pld_pkg::ADDR_LOCK_DETECT);
	wire wr_analog = reg_wr && (reg_addr == pld_pkg::ADDR_ANALOG_EN);
	wire wr_pump   = reg_wr && (reg_addr == pld_pkg::ADDR_CHARGE_PUMP);
	wire wr_ien    = reg_wr && (reg_addr == pld_pkg::ADDR_IRQ_ENABLE);
	wire wr_clr    = reg_wr && (reg_addr == pld_pkg::ADDR_IRQ_CLEAR);

	// Read mux; the clear register and unmapped addresses read zero
	assign rdata_nxt =
		(reg_addr == pld_pkg::ADDR_LOCK_DETECT)  ? {18'h00000, lock_r} :
		(reg_addr == pld_pkg::ADDR_ANALOG_EN)    ? {8'h00, analog_r} :
		(reg_addr == pld_pkg::ADDR_CHARGE_PUMP)  ? {8'h00, pump_r} :
		(reg_addr == pld_pkg::ADDR_IRQ_STATUS)   ? {29'h00000000, status_r} :
		(reg_addr == pld_pkg::ADDR_IRQ_ENABLE)   ? {29'h00000000, irq_en_r} :
		(reg_addr == pld_pkg::ADDR_DETECT_STATE) ? {12'h000, good_cnt_r, 1'b0, relock_used_r,
		                                            win_open_r, (state_r == LD_LOCKED)} :
		32'h00000000;

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	// Reserved bits are stored as written so software sees them back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r   <= pld_pkg::LOCK_CFG_RESET;
			analog_r <= pld_pkg::ANALOG_RESET;
			pump_r   <= pld_pkg::PUMP_RESET;
		end else begin
			if (wr_lock)
				lock_r <= reg_wdata[pld_pkg::LOCK_CFG_W-1:0];
			if (wr_analog)
				analog_r <= reg_wdata[pld_pkg::WIDE_CFG_W-1:0];
			if (wr_pump)
				pump_r <= reg_wdata[pld_pkg::WIDE_CFG_W-1:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? rdata_nxt : 32'h00000000;
	end

	// ---------------------------------------------------------------
	// Window timer rate divider
	// ---------------------------------------------------------------
	// Half-tick enable every 2^rate core cycles, so code 00 is fastest
	wire [2:0] rate_mask = (lock_r.timer_rate == 2'h0) ? 3'h0 :
	                       (lock_r.timer_rate == 2'h1) ? 3'h1 :
	                       (lock_r.timer_rate == 2'h2) ? 3'h3 : 3'h7;
	wire       half_tick = ((rate_cnt_r & rate_mask) == rate_mask);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rate_cnt_r <= 3'h0;
		else
			rate_cnt_r <= rate_cnt_r + 3'h1;
	end

	// ---------------------------------------------------------------
	// Digital window timer
	// ---------------------------------------------------------------
	// Length in half ticks: code 0 is half a timer cycle, code k is 2^(k-1) cycles
	wire [7:0] win_len   = 8'h01 << lock_r.win_len;
	wire       vco_g     = vco_edge && analog_r.divider_clock_to_logic_enable;
	wire       digital   = lock_r.win_digital;
	wire       expire    = win_open_r && half_tick && (win_cnt_r == 8'h01);
	wire       detecting = (state_r != LD_OFF);

	// A hit closes a one-shot window; test mode keeps it cycling
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			win_open_r <= 1'b0;
			win_cnt_r  <= 8'h00;
		end else if (!detecting || !digital) begin
			win_open_r <= 1'b0;
			win_cnt_r  <= 8'h00;
		end else if (ref_edge) begin
			win_open_r <= 1'b1;
			win_cnt_r  <= win_len;
		end else if (expire) begin
			win_open_r <= lock_r.timer_test;
			win_cnt_r  <= lock_r.timer_test ? win_len : 8'h00;
		end else if (vco_g && win_open_r && !lock_r.timer_test) begin
			win_open_r <= 1'b0;
			win_cnt_r  <= 8'h00;
		end else if (win_open_r && half_tick) begin
			win_cnt_r  <= win_cnt_r - 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Lock decision
	// ---------------------------------------------------------------
	// Analog mode trusts the one-shot result; digital mode uses the timer
	// A vco event in the window's last half tick is still a hit, never a miss
	wire        hit    = vco_g && (digital ? win_open_r : analog_in_window);
	wire        miss   = (vco_g && !hit) || (digital && expire && !lock_r.timer_test && !vco_g);
	wire [15:0] target = pld_pkg::lock_target(lock_r.win_count);

	always_comb begin
		state_nxt    = state_r;
		good_cnt_nxt = good_cnt_r;
		relock_nxt   = 1'b0;
		irq_set      = '0;
		case (state_r)
			LD_OFF: begin
				good_cnt_nxt = 16'h0000;
				if (lock_r.ld_enable)
					state_nxt = LD_HUNT;
			end
			LD_HUNT: begin
				if (miss) begin
					good_cnt_nxt = 16'h0000;
				end else if (hit) begin
					if (good_cnt_r >= target - 16'h0001) begin
						state_nxt             = LD_LOCKED;
						irq_set[pld_pkg::IRQ_LOCKED] = 1'b1;
					end else begin
						good_cnt_nxt = good_cnt_r + 16'h0001;
					end
				end
			end
			LD_LOCKED: begin
				if (miss) begin
					state_nxt    = LD_HUNT;
					good_cnt_nxt = 16'h0000;
					irq_set[pld_pkg::IRQ_LOST] = 1'b1;
					// Only one attempt until lock is regained or the detector is switched off
					if (lock_r.auto_relock && !relock_used_r) begin
						relock_nxt = 1'b1;
						irq_set[pld_pkg::IRQ_RELOCK] = 1'b1;
					end
				end
			end
			default: begin
				state_nxt    = LD_OFF;
				good_cnt_nxt = 16'h0000;
			end
		endcase
		if (!lock_r.ld_enable) begin
			state_nxt    = LD_OFF;
			good_cnt_nxt = 16'h0000;
			relock_nxt   = 1'b0;
			irq_set      = '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r       <= LD_OFF;
			good_cnt_r    <= 16'h0000;
			relock_used_r <= 1'b0;
			relock_request <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			good_cnt_r     <= good_cnt_nxt;
			relock_request <= relock_nxt;
			if (relock_nxt)
				relock_used_r <= 1'b1;
			else if (state_nxt == LD_LOCKED || state_nxt == LD_OFF)
				relock_used_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	// A new event in the clearing cycle survives the clear
	assign status_nxt = (status_r & ~(wr_clr ? reg_wdata[pld_pkg::IRQ_W-1:0] : '0)) | irq_set;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= '0;
			irq_en_r <= '0;
			irq      <= 1'b0;
		end else begin
			status_r <= status_nxt;
			if (wr_ien)
				irq_en_r <= reg_wdata[pld_pkg::IRQ_W-1:0];
			irq <= |(status_nxt & (wr_ien ? reg_wdata[pld_pkg::IRQ_W-1:0] : irq_en_r));
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Registered copies; high_gain_pump_mode is withheld while the op-amp is off, pump_cfg passes the bit ungated
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_cfg               <= pld_pkg::LOCK_CFG_RESET;
			analog_cfg             <= pld_pkg::ANALOG_RESET;
			pump_cfg               <= pld_pkg::PUMP_RESET;
			high_gain_pump_mode    <= 1'b0;
			lock_detected          <= 1'b0;
			lock_serial_out_pin_o  <= 1'b0;
			lock_serial_out_pin_oe <= 1'b0;
		end else begin
			lock_cfg               <= lock_r;
			analog_cfg             <= analog_r;
			pump_cfg               <= pump_r;
			high_gain_pump_mode    <= pump_r.high_gain_pump_mode && analog_r.opamp_enable;
			lock_detected          <= (state_r == LD_LOCKED);
			lock_serial_out_pin_o  <= (state_r == LD_LOCKED);
			lock_serial_out_pin_oe <= analog_r.shared_output_pad_enable;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_lock_count;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == LD_HUNT) && (state_nxt == LD_LOCKED) |-> hit && (good_cnt_r + 16'h0001 >= target);
	endproperty
	a_lock_count: assert property (p_lock_count) else $error("lock declared too early");

	property p_ld_disable;
		@(posedge core_clk) disable iff (!rst_n)
		!lock_r.ld_enable |=> (state_r == LD_OFF) ##1 !lock_detected;
	endproperty
	a_ld_disable: assert property (p_ld_disable) else $error("detector ran while disabled");

	property p_analog_miss;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == LD_HUNT) && !digital && vco_g && !analog_in_window && lock_r.ld_enable
			|=> (good_cnt_r == 16'h0000);
	endproperty
	a_analog_miss: assert property (p_analog_miss) else $error("analog miss not counted");

	property p_win_load;
		@(posedge core_clk) disable iff (!rst_n)
		detecting && digital && ref_edge && !wr_lock |=> win_open_r && (win_cnt_r == $past(win_len));
	endproperty
	a_win_load: assert property (p_win_load) else $error("window length wrong");

	property p_slow_rate;
		@(posedge core_clk) disable iff (!rst_n)
		half_tick && (lock_r.timer_rate == 2'h3) |=> (!half_tick || lock_r.timer_rate != 2'h3)[*7];
	endproperty
	a_slow_rate: assert property (p_slow_rate) else $error("slowest timer rate too fast");

	property p_timer_test;
		@(posedge core_clk) disable iff (!rst_n)
		expire && lock_r.timer_test && detecting && digital && lock_r.ld_enable && !wr_lock
			|=> win_open_r;
	endproperty
	a_timer_test: assert property (p_timer_test) else $error("test timer stopped");

	property p_one_relock;
		@(posedge core_clk) disable iff (!rst_n)
		relock_request |-> !$past(relock_used_r) ##1 !relock_request;
	endproperty
	a_one_relock: assert property (p_one_relock) else $error("second relock attempt");

	property p_pad_off;
		@(posedge core_clk) disable iff (!rst_n)
		wr_analog && !reg_wdata[5] |=> ##1 !lock_serial_out_pin_oe;
	endproperty
	a_pad_off: assert property (p_pad_off) else $error("pad still driven");

	property p_readback;
		@(posedge core_clk) disable iff (!rst_n)
		wr_pump ##1 (reg_rd && reg_addr == pld_pkg::ADDR_CHARGE_PUMP && !reg_wr)
			|=> (reg_rdata == {8'h00, $past(reg_wdata[23:0], 2)});
	endproperty
	a_readback: assert property (p_readback) else $error("pump register read back wrong");

	property p_high_gain;
		@(posedge core_clk) disable iff (!rst_n)
		high_gain_pump_mode |-> $past(analog_r.opamp_enable) && $past(pump_r.high_gain_pump_mode);
	endproperty
	a_high_gain: assert property (p_high_gain) else $error("high gain without op-amp");

	property p_rdata_idle;
		@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> (reg_rdata == 32'h00000000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

	property p_gated_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == LD_HUNT) && !digital && lock_r.ld_enable && !analog_r.divider_clock_to_logic_enable
			|=> (state_r == LD_HUNT) && (good_cnt_r == $past(good_cnt_r));
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("gated divider clock moved detector");

	property p_window_hit;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == LD_LOCKED) && digital && lock_r.ld_enable && vco_g && win_open_r
			|=> (state_r == LD_LOCKED);
	endproperty
	a_window_hit: assert property (p_window_hit) else $error("in-window hit dropped lock");

	property p_no_auto_relock;
		@(posedge core_clk) disable iff (!rst_n)
		!lock_r.auto_relock |=> !relock_request;
	endproperty
	a_no_auto_relock: assert property (p_no_auto_relock) else $error("relock without auto relock");

endmodule

// ===== test/tb.sv
// Self-checking bench for the lock detector and bias register bank.
// Assumes one 40 MHz core clock, the plain single-cycle register port and no partner model.
`timescale 1ns/100ps

module tb;

	// ---------------------------------------------------------------
	// Signals and bookkeeping
	// ---------------------------------------------------------------
	logic                     core_clk;
	logic                     rst_n;
	logic [7:0]               reg_addr;
	logic [31:0]              reg_wdata;
	logic                     reg_wr;
	logic                     reg_rd;
	logic [31:0]              reg_rdata;
	logic                     ref_edge;
	logic                     vco_edge;
	logic                     analog_in_window;
	pld_pkg::pld_lock_cfg_t   lock_cfg;
	pld_pkg::pld_analog_cfg_t analog_cfg;
	pld_pkg::pld_pump_cfg_t   pump_cfg;
	logic                     high_gain_pump_mode;
	logic                     lock_detected;
	logic                     relock_request;
	logic                     irq;
	logic                     pin_o;
	logic                     pin_oe;
	logic [31:0]              exp_q[$];
	logic                     rd_seen;
	int                       bad_count;
	int                       n_tests;
	int                       relock_cnt;
	int                       seed_ret;

	pld_regs DUT (
		.core_clk              (core_clk),
		.rst_n                 (rst_n),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.ref_edge              (ref_edge),
		.vco_edge              (vco_edge),
		.analog_in_window      (analog_in_window),
		.lock_cfg              (lock_cfg),
		.analog_cfg            (analog_cfg),
		.pump_cfg              (pump_cfg),
		.high_gain_pump_mode   (high_gain_pump_mode),
		.lock_detected         (lock_detected),
		.relock_request        (relock_request),
		.irq                   (irq),
		.lock_serial_out_pin_o (pin_o),
		.lock_serial_out_pin_oe(pin_oe)
	);

	// 25 ns period
	always #12.5 core_clk = ~core_clk;

	// ---------------------------------------------------------------
	// Compare tasks and output monitor
	// ---------------------------------------------------------------
	task automatic cmp_val(input logic [31:0] act, input logic [31:0] exp);
		n_tests++;
		if (act !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, act, exp);
		end
	endtask

	task automatic cmp_rd(input logic [31:0] act, input logic [31:0] exp);
		n_tests++;
		if (act !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t read %h exp %h", $time, act, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe, so look mid-cycle
	always @(posedge core_clk) begin
		rd_seen <= reg_rd;
		if (relock_request === 1'b1)
			relock_cnt <= relock_cnt + 1;
	end

	always @(negedge core_clk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			cmp_rd(reg_rdata, exp_q.pop_front());
	end

	// ---------------------------------------------------------------
	// Bus and event drivers
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		exp_q.push_back(e);
	endtask

	// Drops the strobes, lets n edges pass, then stops mid-cycle for checks
	task automatic idle(input int n);
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic ev(input logic r, input logic v, input logic w, input int gap);
		@(posedge core_clk);
		reg_wr           <= 1'b0;
		reg_rd           <= 1'b0;
		ref_edge         <= r;
		vco_edge         <= v;
		analog_in_window <= w;
		@(posedge core_clk);
		ref_edge         <= 1'b0;
		vco_edge         <= 1'b0;
		analog_in_window <= 1'b0;
		repeat (gap) @(posedge core_clk);
	endtask

	// Digital-mode comparison: vco follows ref by d+2 cycles
	task automatic dhit(input int d);
		ev(1'b1, 1'b0, 1'b0, d);
		ev(1'b0, 1'b1, 1'b0, 1);
	endtask

	task automatic close_out();
		// A read whose data never showed up counts against the run
		if (exp_q.size() != 0)
			bad_count++;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Whole run is well under a thousand cycles; this is a generous ceiling
	initial begin
		repeat (6000) @(posedge core_clk);
		bad_count++;
		$display("watchdog expired");
		close_out();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin : main
		logic [31:0] d [3];
		logic [31:0] m [3];
		core_clk = 1'b0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0;
		reg_rd = 1'b0; ref_edge = 1'b0; vco_edge = 1'b0; analog_in_window = 1'b0;
		rd_seen = 1'b0; bad_count = 0; n_tests = 0; relock_cnt = 0;
		m[0] = 32'h3fff; m[1] = 32'hffffff; m[2] = 32'hffffff;
		seed_ret = $urandom(32'hfea1a9c1);
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		idle(3);
		// Reset values on reads and on the pump configuration and pad enable outputs
		rd(pld_pkg::ADDR_LOCK_DETECT, {18'h0, pld_pkg::LOCK_CFG_RESET});
		rd(pld_pkg::ADDR_ANALOG_EN, {8'h0, pld_pkg::ANALOG_RESET});
		rd(pld_pkg::ADDR_CHARGE_PUMP, {8'h0, pld_pkg::PUMP_RESET});
		rd(pld_pkg::ADDR_IRQ_STATUS, 32'h0);
		idle(1);
		cmp_val({8'h0, pump_cfg}, {8'h0, pld_pkg::PUMP_RESET});
		cmp_val({31'h0, pin_oe}, 32'h1);
		$display("reset test done");
		// Random write then immediate read, back to back; reserved analog bits 20 and 18 kept zero
		for (int i = 0; i < 3; i++) begin
			d[i] = $urandom() & m[i];
			if (i == 1)
				d[i] = d[i] & 32'hffebffff;
			wr(pld_pkg::ADDR_LOCK_DETECT + 8'(i), $urandom() & 32'hff000000 | d[i]);
			rd(pld_pkg::ADDR_LOCK_DETECT + 8'(i), d[i]);
		end
		rd(8'h20, 32'h0);
		rd(pld_pkg::ADDR_IRQ_CLEAR, 32'h0);
		idle(2);
		cmp_val({18'h0, lock_cfg}, d[0]);
		cmp_val({8'h0, analog_cfg}, d[1]);
		cmp_val({8'h0, pump_cfg}, d[2]);
		$display("readback test done");
		// High gain pump needs the op-amp; pad enable drives the shared pin
		wr(pld_pkg::ADDR_CHARGE_PUMP, {8'h0, pld_pkg::PUMP_RESET | 24'h800000});
		wr(pld_pkg::ADDR_ANALOG_EN, {8'h0, pld_pkg::ANALOG_RESET & 24'hfff7df});
		idle(2);
		cmp_val({31'h0, high_gain_pump_mode}, 32'h0);
		cmp_val({31'h0, pin_oe}, 32'h0);
		wr(pld_pkg::ADDR_ANALOG_EN, {8'h0, pld_pkg::ANALOG_RESET});
		idle(2);
		cmp_val({31'h0, high_gain_pump_mode}, 32'h1);
		cmp_val({31'h0, pin_oe}, 32'h1);
		$display("pump and pad test done");
		// Analog lock at five hits, one relock attempt only, interrupt handling
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h2008);
		wr(pld_pkg::ADDR_CHARGE_PUMP, {8'h0, pld_pkg::PUMP_RESET});
		wr(pld_pkg::ADDR_IRQ_CLEAR, 32'h7);
		wr(pld_pkg::ADDR_IRQ_ENABLE, 32'h1);
		idle(3);
		repeat (4) ev(1'b0, 1'b1, 1'b1, 1);
		idle(3);
		cmp_val({30'h0, irq, lock_detected}, 32'h0);
		ev(1'b0, 1'b1, 1'b1, 1);
		idle(3);
		cmp_val({29'h0, irq, pin_o, lock_detected}, 32'h7);
		rd(pld_pkg::ADDR_IRQ_STATUS, 32'h1);
		ev(1'b0, 1'b1, 1'b0, 1);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h0);
		cmp_val(32'(relock_cnt), 32'h1);
		rd(pld_pkg::ADDR_IRQ_STATUS, 32'h7);
		repeat (3) ev(1'b0, 1'b1, 1'b1, 1);
		ev(1'b0, 1'b1, 1'b0, 1);
		idle(3);
		cmp_val(32'(relock_cnt), 32'h1);
		wr(pld_pkg::ADDR_IRQ_ENABLE, 32'h0);
		idle(2);
		cmp_val({31'h0, irq}, 32'h0);
		wr(pld_pkg::ADDR_IRQ_ENABLE, 32'h4);
		idle(2);
		cmp_val({31'h0, irq}, 32'h1);
		wr(pld_pkg::ADDR_IRQ_CLEAR, 32'h7);
		idle(2);
		cmp_val({31'h0, irq}, 32'h0);
		rd(pld_pkg::ADDR_IRQ_STATUS, 32'h0);
		$display("analog lock test done");
		// Detector off, then divider clock gated: no lock either way
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0000);
		idle(2);
		repeat (5) ev(1'b0, 1'b1, 1'b1, 1);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h0);
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0008);
		wr(pld_pkg::ADDR_ANALOG_EN, {8'h0, pld_pkg::ANALOG_RESET & 24'hffff7f});
		idle(3);
		repeat (5) ev(1'b0, 1'b1, 1'b1, 1);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h0);
		wr(pld_pkg::ADDR_ANALOG_EN, {8'h0, pld_pkg::ANALOG_RESET});
		idle(2);
		repeat (5) ev(1'b0, 1'b1, 1'b1, 1);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h1);
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0000);
		idle(2);
		cmp_val({31'h0, lock_detected}, 32'h0);
		$display("disable test done");
		// Digital window of four half ticks at the fastest rate
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0148);
		idle(3);
		repeat (5) dhit(0);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h1);
		// Answer in the window's last half tick keeps lock
		dhit(2);
		idle(1);
		cmp_val({31'h0, lock_detected}, 32'h1);
		ev(1'b1, 1'b0, 1'b0, 10);
		idle(1);
		cmp_val({31'h0, lock_detected}, 32'h0);
		repeat (5) dhit(10);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h0);
		// Slowest rate stretches the same window past twelve cycles
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0000);
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0d48);
		idle(3);
		repeat (5) dhit(10);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h1);
		// Continuous timer: an unanswered window never counts against lock
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h0000);
		wr(pld_pkg::ADDR_LOCK_DETECT, 32'h1148);
		idle(3);
		repeat (5) dhit(0);
		idle(3);
		cmp_val({31'h0, lock_detected}, 32'h1);
		ev(1'b1, 1'b0, 1'b0, 40);
		idle(1);
		cmp_val({31'h0, lock_detected}, 32'h1);
		$display("digital window test done");
		idle(2);
		close_out();
	end

endmodule
